// ===== rtl/crs_defines.vh
// Constants of the core register set: offsets, flag positions, opcodes, reset values.
`ifndef CRS_DEFINES_VH
`define CRS_DEFINES_VH
// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define CRS_A_ACC     8'h00
`define CRS_A_IDX_X   8'h04
`define CRS_A_IDX_Y   8'h08
`define CRS_A_SPTR    8'h0C
`define CRS_A_PCNT    8'h10
`define CRS_A_STATUS  8'h14
`define CRS_A_MODE    8'h18
`define CRS_A_CMD     8'h1C
`define CRS_A_MADR    8'h20
`define CRS_A_MDAT    8'h24
`define CRS_A_STATE   8'h28
// ----------------------------------------------------------------
// Flag positions, mode and state bits
// ----------------------------------------------------------------
`define CRS_F_C       0
`define CRS_F_Z       1
`define CRS_F_I       2
`define CRS_F_D       3
`define CRS_F_B       4
`define CRS_F_T       5
`define CRS_F_V       6
`define CRS_F_N       7
`define CRS_FLAG_WMASK 8'h6D
`define CRS_MODE_SPS  2
`define CRS_ST_UNSUP  2
// ----------------------------------------------------------------
// Command fields and opcodes
// ----------------------------------------------------------------
`define CRS_CMD_OP    4:0
`define CRS_CMD_IDX   6:5
`define CRS_CMD_OPND  15:8
`define CRS_CMD_AUX   23:16
`define CRS_OP_ADD_CARRY     5'h01
`define CRS_OP_SUB_BORROW    5'h02
`define CRS_OP_LOAD          5'h03
`define CRS_OP_STORE         5'h04
`define CRS_OP_SHIFT_L       5'h05
`define CRS_OP_ROTATE_L      5'h06
`define CRS_OP_TEST_BITS     5'h07
`define CRS_OP_PUSH_ACC      5'h08
`define CRS_OP_PULL_ACC      5'h09
`define CRS_OP_PUSH_STATUS   5'h0A
`define CRS_OP_PULL_STATUS   5'h0B
`define CRS_OP_CALL          5'h0C
`define CRS_OP_SW_BREAK      5'h0D
`define CRS_OP_PRODUCT       5'h0E
`define CRS_OP_DIVIDE        5'h0F
`define CRS_OP_WAIT          5'h10
`define CRS_OP_STOP          5'h11
`define CRS_OP_UNSUP_FAST_A  5'h12
`define CRS_OP_UNSUP_SLOW_B  5'h13
`define CRS_OP_FLAGS         5'h14
`define CRS_OP_BRANCH        5'h15
// ----------------------------------------------------------------
// Reset values and vectors
// ----------------------------------------------------------------
`define CRS_RST_STATUS 8'h04
`define CRS_RST_SPTR   8'hFF
`define CRS_RST_MODE   8'h00
`define CRS_VEC_IRQ    16'hFFFC
`define CRS_VEC_BRK    16'hFFDC
`endif

// ===== rtl/crs_core_regs.v
// Programmer-visible register set of the 8-bit core with an APB command port.
`timescale 1ns/100ps
`include "crs_defines.vh"
// Function
// - Eight-bit accumulator is main operand and destination of transfers and arithmetic.
// - Two eight-bit index registers; indexed address is operand plus chosen index.
// - With index-mode flag set, X holds the address of the second operand.
// - Eight-bit stack pointer gives low stack address byte for calls and interrupts.
// - Stack page bit picks page zero or page one for the stack.
// - Calls push the return address; interrupts and the software break push it and the status.
// - Sixteen-bit program counter built of high and low byte registers.
// - Eight-bit status of flags; branches test carry, zero, overflow, negative.
// - After decimal arithmetic zero, overflow and negative flags carry no meaning.
// - Reset sets interrupt disable; software initialises index-mode and decimal flags.
// - Carry takes arithmetic carry or borrow; shifts and rotates update it too.
// - Zero flag set for zero result, cleared for any other result.
// - Interrupt disable blocks all requests except the software break.
// - Accepting an interrupt sets interrupt disable automatically.
// - Decimal flag selects binary or corrected decimal add and subtract.
// - Live break flag reads zero; only the software break pushed copy has it.
// - Index-mode flag clear: arithmetic uses accumulator and memory, result in accumulator.
// - Index-mode flag set: memory-to-memory operation, result to first location.
// - Two optional ops unsupported; multiply, divide, wait and stop supported.
// - Push and pull exist for the accumulator and for the status.
// - Overflow flags signed range excess; bit test copies operand bit 6.
// - Negative follows result sign; bit test copies operand bit 7.
// - Stack page bit lives in the core mode register.
module crs_core_regs (
  input  wire        clk,
  input  wire        srst,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire        irq_request,
  output reg         irq_ack,
  output wire        core_waiting,
  output wire        core_stopped
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  localparam [5:0] S_IDLE = 6'h01;
  localparam [5:0] S_PHI  = 6'h02;
  localparam [5:0] S_PLO  = 6'h04;
  localparam [5:0] S_PPS  = 6'h08;
  localparam [5:0] S_WAIT = 6'h10;
  localparam [5:0] S_STOP = 6'h20;

  reg [7:0]  acc;
  reg [7:0]  idx_x;
  reg [7:0]  idx_y;
  reg [7:0]  stack_ptr;
  reg [7:0]  program_counter_high;
  reg [7:0]  program_counter_low;
  reg [7:0]  processor_status;
  reg [7:0]  core_mode_register;
  reg [8:0]  mem_addr;
  reg        unsup;
  reg [5:0]  state;
  reg [15:0] seq_ret;
  reg [15:0] seq_tgt;
  reg        seq_int;
  reg        seq_brk;
  reg        busy_q;
  reg [7:0]  ram [0:511];

  // ----------------------------------------------------------------
  // Decode and address arithmetic
  // ----------------------------------------------------------------
  wire        busy     = state[1] | state[2] | state[3];
  wire        acc_ok   = psel & penable & pready;
  wire        wr_en    = acc_ok & pwrite;
  wire        cmd_go   = wr_en & (paddr == `CRS_A_CMD) & state[0];
  wire [4:0]  op       = pwdata[`CRS_CMD_OP];
  wire [1:0]  isel     = pwdata[`CRS_CMD_IDX];
  wire [7:0]  opnd     = pwdata[`CRS_CMD_OPND];
  wire [7:0]  aux      = pwdata[`CRS_CMD_AUX];
  wire [15:0] program_counter = {program_counter_high, program_counter_low};
  wire [7:0]  idx_val  = (isel == 2'h1) ? idx_x : (isel == 2'h2) ? idx_y : 8'h00;
  wire [8:0]  ea_sum   = {1'b0, opnd} + {1'b0, idx_val};
  wire [7:0]  ea       = ea_sum[7:0];
  wire        t_mode   = processor_status[`CRS_F_T];
  wire        carry    = processor_status[`CRS_F_C];
  wire        page     = core_mode_register[`CRS_MODE_SPS];
  wire [8:0]  push_a   = {page, stack_ptr};
  wire [8:0]  spd      = {1'b0, stack_ptr} - 9'h001;
  wire [8:0]  spi      = {1'b0, stack_ptr} + 9'h001;
  wire [8:0]  pull_a   = {page, spi[7:0]};
  wire [7:0]  pulled   = ram[pull_a];
  wire [7:0]  mem_ea   = ram[{1'b0, ea}];
  wire [7:0]  mem_x    = ram[{1'b0, idx_x}];
  wire [7:0]  opa      = t_mode ? mem_ea : acc;
  wire [7:0]  opb      = t_mode ? mem_x : mem_ea;
  wire [16:0] pci      = {1'b0, program_counter} + 17'h00001;
  wire [15:0] pcnt_inc = pci[15:0];
  wire [16:0] pcb      = {1'b0, pcnt_inc} + {{9{opnd[7]}}, opnd};
  wire [15:0] product  = acc * mem_ea;
  wire [15:0] divd     = {idx_y, acc};
  wire [15:0] quo      = (mem_ea == 8'h00) ? 16'hFFFF : divd / {8'h00, mem_ea};
  wire [15:0] rem      = (mem_ea == 8'h00) ? {8'h00, acc} : divd % {8'h00, mem_ea};
  wire [2:0]  bsel     = aux[2:0];
  wire        bflag_ok = (bsel == 3'h0) | (bsel == 3'h1) | (bsel == 3'h6) | (bsel == 3'h7);
  wire        b_taken  = bflag_ok & (processor_status[bsel] == aux[3]);
  wire [7:0]  fmask    = opnd & `CRS_FLAG_WMASK;
  wire [7:0]  live_flg = {processor_status[7:5], 1'b0, processor_status[3:0]};

  assign pready       = ~busy & ~busy_q;
  assign core_waiting = state[4];
  assign core_stopped = state[5];

  // ----------------------------------------------------------------
  // Arithmetic unit
  // ----------------------------------------------------------------
  reg [7:0] alu_res;
  reg       alu_c;
  reg       alu_v;
  reg [7:0] binv;
  reg [8:0] bin;
  reg [4:0] lo;
  reg [4:0] hi;
  reg       lb;
  reg       hb;
  always @* begin
    binv = (op == `CRS_OP_SUB_BORROW) ? ~opb : opb;
    bin  = {1'b0, opa} + {1'b0, binv} + {8'h00, carry};
    lo   = 5'h00;
    hi   = 5'h00;
    lb   = 1'b0;
    hb   = 1'b0;
    alu_res = bin[7:0];
    alu_c   = bin[8];
    alu_v   = (opa[7] == binv[7]) & (bin[7] != opa[7]);
    if (processor_status[`CRS_F_D]) begin
      if (op == `CRS_OP_ADD_CARRY) begin
        lo = {1'b0, opa[3:0]} + {1'b0, opb[3:0]} + {4'h0, carry};
        if (lo > 5'h09) begin
          lo = lo + 5'h06;
        end
        hi = {1'b0, opa[7:4]} + {1'b0, opb[7:4]} + {4'h0, lo[4]};
        if (hi > 5'h09) begin
          hi = hi + 5'h06;
        end
        alu_res = {hi[3:0], lo[3:0]};
        alu_c   = hi[4];
      end else begin
        lo = {1'b0, opa[3:0]} - {1'b0, opb[3:0]} - {4'h0, ~carry};
        lb = lo[4];
        if (lb) begin
          lo = lo - 5'h06;
        end
        hi = {1'b0, opa[7:4]} - {1'b0, opb[7:4]} - {4'h0, lb};
        hb = hi[4];
        if (hb) begin
          hi = hi - 5'h06;
        end
        alu_res = {hi[3:0], lo[3:0]};
        alu_c   = ~hb;
      end
    end
  end

  // ----------------------------------------------------------------
  // Registers, commands and stack sequencer
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    busy_q  <= busy;
    irq_ack <= 1'b0;
    if (srst) begin
      acc                  <= 8'h00;
      idx_x                <= 8'h00;
      idx_y                <= 8'h00;
      stack_ptr            <= `CRS_RST_SPTR;
      program_counter_high <= 8'h00;
      program_counter_low  <= 8'h00;
      processor_status     <= `CRS_RST_STATUS;
      core_mode_register   <= `CRS_RST_MODE;
      mem_addr             <= 9'h000;
      unsup                <= 1'b0;
      state                <= S_IDLE;
      seq_ret              <= 16'h0000;
      seq_tgt              <= 16'h0000;
      seq_int              <= 1'b0;
      seq_brk              <= 1'b0;
      busy_q               <= 1'b0;
    end else begin
      if (wr_en) begin
        case (paddr)
          `CRS_A_ACC:    acc <= pwdata[7:0];
          `CRS_A_IDX_X:  idx_x <= pwdata[7:0];
          `CRS_A_IDX_Y:  idx_y <= pwdata[7:0];
          `CRS_A_SPTR:   stack_ptr <= pwdata[7:0];
          `CRS_A_PCNT:   {program_counter_high, program_counter_low} <= pwdata[15:0];
          `CRS_A_STATUS: processor_status <= {pwdata[7:5], 1'b0, pwdata[3:0]};
          `CRS_A_MODE:   core_mode_register <= pwdata[7:0];
          `CRS_A_MADR:   mem_addr <= pwdata[8:0];
          `CRS_A_MDAT:   ram[mem_addr] <= pwdata[7:0];
          `CRS_A_STATE:  if (pwdata[`CRS_ST_UNSUP]) unsup <= 1'b0;
          default: ;
        endcase
      end
      if (cmd_go) begin
        {program_counter_high, program_counter_low} <= pcnt_inc;
        case (op)
          `CRS_OP_ADD_CARRY, `CRS_OP_SUB_BORROW: begin
            if (t_mode) begin
              ram[{1'b0, ea}] <= alu_res;
            end else begin
              acc <= alu_res;
            end
            processor_status[`CRS_F_C] <= alu_c;
            processor_status[`CRS_F_V] <= alu_v;
            processor_status[`CRS_F_Z] <= (alu_res == 8'h00);
            processor_status[`CRS_F_N] <= alu_res[7];
          end
          `CRS_OP_LOAD: begin
            if (t_mode) begin
              ram[{1'b0, ea}] <= opb;
            end else begin
              acc <= mem_ea;
            end
            processor_status[`CRS_F_Z] <= (opb == 8'h00);
            processor_status[`CRS_F_N] <= opb[7];
          end
          `CRS_OP_STORE: ram[{1'b0, ea}] <= acc;
          `CRS_OP_SHIFT_L, `CRS_OP_ROTATE_L: begin
            acc <= {acc[6:0], (op == `CRS_OP_ROTATE_L) & carry};
            processor_status[`CRS_F_C] <= acc[7];
            processor_status[`CRS_F_Z] <= ({acc[6:0], (op == `CRS_OP_ROTATE_L) & carry}
                                           == 8'h00);
            processor_status[`CRS_F_N] <= acc[6];
          end
          `CRS_OP_TEST_BITS: begin
            processor_status[`CRS_F_Z] <= ((acc & mem_ea) == 8'h00);
            processor_status[`CRS_F_V] <= mem_ea[6];
            processor_status[`CRS_F_N] <= mem_ea[7];
          end
          `CRS_OP_PUSH_ACC, `CRS_OP_PUSH_STATUS: begin
            ram[push_a] <= (op == `CRS_OP_PUSH_ACC) ? acc : live_flg;
            stack_ptr   <= spd[7:0];
          end
          `CRS_OP_PULL_ACC: begin
            stack_ptr <= spi[7:0];
            acc       <= pulled;
            processor_status[`CRS_F_Z] <= (pulled == 8'h00);
            processor_status[`CRS_F_N] <= pulled[7];
          end
          `CRS_OP_PULL_STATUS: begin
            stack_ptr        <= spi[7:0];
            processor_status <= {pulled[7:5], 1'b0, pulled[3:0]};
          end
          `CRS_OP_CALL, `CRS_OP_SW_BREAK: begin
            seq_ret <= pcnt_inc;
            seq_int <= (op == `CRS_OP_SW_BREAK);
            seq_brk <= (op == `CRS_OP_SW_BREAK);
            seq_tgt <= (op == `CRS_OP_CALL) ? {aux, opnd} : `CRS_VEC_BRK;
            state   <= S_PHI;
          end
          `CRS_OP_PRODUCT: begin
            acc   <= product[7:0];
            idx_y <= product[15:8];
          end
          `CRS_OP_DIVIDE: begin
            acc   <= quo[7:0];
            idx_y <= rem[7:0];
          end
          `CRS_OP_WAIT: state <= S_WAIT;
          `CRS_OP_STOP: state <= S_STOP;
          `CRS_OP_UNSUP_FAST_A, `CRS_OP_UNSUP_SLOW_B: unsup <= 1'b1;
          `CRS_OP_FLAGS: processor_status <= (processor_status & ~fmask) | (aux & fmask);
          `CRS_OP_BRANCH: begin
            if (b_taken) begin
              {program_counter_high, program_counter_low} <= pcb[15:0];
            end
          end
          default: ;
        endcase
      end
      case (state)
        S_IDLE, S_WAIT, S_STOP: begin
          if (irq_request & ~processor_status[`CRS_F_I] & ~cmd_go) begin
            seq_ret <= program_counter;
            seq_tgt <= `CRS_VEC_IRQ;
            seq_int <= 1'b1;
            seq_brk <= 1'b0;
            state   <= S_PHI;
          end else if (irq_request & ~state[0]) begin
            state <= S_IDLE;
          end
        end
        S_PHI: begin
          ram[push_a] <= seq_ret[15:8];
          stack_ptr   <= spd[7:0];
          state       <= S_PLO;
        end
        S_PLO: begin
          ram[push_a] <= seq_ret[7:0];
          stack_ptr   <= spd[7:0];
          if (seq_int) begin
            state <= S_PPS;
          end else begin
            {program_counter_high, program_counter_low} <= seq_tgt;
            state <= S_IDLE;
          end
        end
        S_PPS: begin
          ram[push_a] <= {processor_status[7:5], seq_brk, processor_status[3:0]};
          stack_ptr   <= spd[7:0];
          processor_status[`CRS_F_I] <= 1'b1;
          {program_counter_high, program_counter_low} <= seq_tgt;
          irq_ack <= ~seq_brk;
          state   <= S_IDLE;
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // APB read path
  // ----------------------------------------------------------------
  reg [31:0] rdat;
  reg        hit;
  always @* begin
    rdat = 32'h00000000;
    hit  = 1'b1;
    case (paddr)
      `CRS_A_ACC:    rdat[7:0]  = acc;
      `CRS_A_IDX_X:  rdat[7:0]  = idx_x;
      `CRS_A_IDX_Y:  rdat[7:0]  = idx_y;
      `CRS_A_SPTR:   rdat[7:0]  = stack_ptr;
      `CRS_A_PCNT:   rdat[15:0] = program_counter;
      `CRS_A_STATUS: rdat[7:0]  = live_flg;
      `CRS_A_MODE:   rdat[7:0]  = core_mode_register;
      `CRS_A_CMD:    rdat       = 32'h00000000;
      `CRS_A_MADR:   rdat[8:0]  = mem_addr;
      `CRS_A_MDAT:   rdat[7:0]  = ram[mem_addr];
      `CRS_A_STATE:  rdat = {7'h00, push_a, 12'h000, busy, unsup, state[5], state[4]};
      default:       hit  = 1'b0;
    endcase
  end

  assign pslverr = acc_ok & ~hit;

  always @(posedge clk) begin
    if (srst) begin
      prdata <= 32'h00000000;
    end else begin
      prdata <= rdat;
    end
  end
endmodule // crs_core_regs

// ===== tb/crs_core_regs_assertions.sv
// Concurrent checks on the ports of the core register set.
`timescale 1ns/100ps
module crs_core_regs_assertions (
  input wire        clk,
  input wire        srst,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [7:0]  paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  input wire        irq_request,
  input wire        irq_ack,
  input wire        core_waiting,
  input wire        core_stopped
);
  wire mapped;
  wire rd_done;
  assign mapped = (paddr[1:0] == 2'h0) && (paddr <= 8'h28);
  assign rd_done = psel && penable && pready && !pwrite;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);
  // ----------------------------------------------------------------
  // Sleep state sequences
  // ----------------------------------------------------------------
  sequence s_asleep;
    core_waiting || core_stopped;
  endsequence
  sequence s_awake;
    !core_waiting && !core_stopped;
  endsequence
  a_err_decode: assert property (psel && penable && pready |-> pslverr == !mapped)
    else $error("pslverr does not match address decode");
  a_err_idle: assert property (!penable |-> !pslverr)
    else $error("pslverr outside an access");
  a_unmapped_zero: assert property (rd_done && !mapped |-> prdata == 32'h00000000)
    else $error("unmapped read returned data");
  a_cmd_reads_zero: assert property (rd_done && paddr == 8'h1C |-> prdata == 32'h00000000)
    else $error("command word read back nonzero");
  a_ack_pulse: assert property (irq_ack |=> !irq_ack)
    else $error("irq_ack longer than one cycle");
  a_ack_cause: assert property (irq_ack |-> irq_request && !pready)
    else $error("irq_ack without request or while idle");
  a_ack_release: assert property (irq_ack |-> ##[1:2] pready)
    else $error("bus not released after interrupt entry");
  a_sleep_excl: assert property (!(core_waiting && core_stopped))
    else $error("waiting and stopped together");
  a_sleep_hold: assert property (s_asleep ##0 !irq_request |=> s_asleep)
    else $error("sleep left without a request");
  a_sleep_wake: assert property (s_asleep ##0 irq_request |-> ##[1:2] s_awake)
    else $error("request did not wake the core");
  a_reset_quiet: assert property ($fell(srst) |-> prdata == 32'h00000000 && !irq_ack
    && !core_waiting && !core_stopped)
    else $error("outputs not quiet after reset");
endmodule // crs_core_regs_assertions

bind crs_core_regs crs_core_regs_assertions i_chk (
  .clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .irq_request(irq_request), .irq_ack(irq_ack), .core_waiting(core_waiting),
  .core_stopped(core_stopped));

// ===== tb/cpu_register_set_tb.sv
// Self-checking testbench of the core register set.
`timescale 1ns/100ps
`include "crs_defines.vh"
module cpu_register_set_tb;
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic        irq_request = 1'b0;
  wire  [31:0] prdata;
  wire         pready;
  wire         pslverr;
  wire         irq_ack;
  wire         core_waiting;
  wire         core_stopped;
  int          failures = 0;
  int          samples_checked = 0;
  logic [31:0] seed = 32'h00006985;
  logic [31:0] q;
  logic        e;
  logic [7:0]  a, m, mm, o;
  logic [8:0]  r;
  logic        c, sb;
  logic [31:0] n;
  logic [7:0]  ra [9] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h28};
  logic [31:0] rv [9] = '{32'h00, 32'h00, 32'h00, 32'hFF, 32'h00, 32'h04, 32'h00, 32'h00,
                          32'h00FF0000};

  crs_core_regs i_dut (.clk(clk), .srst(srst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq_request(irq_request), .irq_ack(irq_ack),
    .core_waiting(core_waiting), .core_stopped(core_stopped));

  initial begin
    forever #2.5 clk = ~clk;
  end
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task wrap_up;
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    samples_checked++;
    if (got !== ex) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, ex, got);
    end
  endtask
  function void rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
  endfunction
  // Holds the request until pready is sampled high, then idles one cycle.
  task apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    int k;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 200);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 200) begin
      failures++;
      wrap_up();
    end
    @(posedge clk);
  endtask
  task wr(input logic [7:0] ad, input logic [31:0] d);
    apb(1'b1, ad, d);
  endtask
  task rchk(input logic [7:0] ad, input string nm, input logic [31:0] ex);
    apb(1'b0, ad, 32'h00000000);
    chk(nm, ex, q);
  endtask
  task ram_wr(input logic [8:0] ad, input logic [7:0] d);
    wr(`CRS_A_MADR, {23'h000000, ad});
    wr(`CRS_A_MDAT, {24'h000000, d});
  endtask
  task ram_chk(input logic [8:0] ad, input logic [7:0] mask, input logic [7:0] ex);
    wr(`CRS_A_MADR, {23'h000000, ad});
    apb(1'b0, `CRS_A_MDAT, 32'h00000000);
    chk("ram", {24'h000000, ex}, q & {24'h000000, mask});
  endtask
  task cmd(input logic [4:0] op, input logic [7:0] od, input logic [7:0] ax,
           input logic [1:0] ix);
    wr(`CRS_A_CMD, {8'h00, ax, od, 1'b0, ix, op});
  endtask
  function logic [7:0] st_exp(input logic [7:0] x, input logic [7:0] y, input logic [8:0] s);
    logic [7:0] ov;
    ov = ~(x ^ y) & (x ^ s[7:0]);
    return {s[7], ov[7], 4'h0, s[7:0] == 8'h00, s[8]};
  endfunction
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < 9; i++) rchk(ra[i], "reset value", rv[i]);
    for (int i = 0; i < 16; i++) begin
      rnd();
      a = (i == 0) ? 8'h7F : seed[7:0];
      m = (i == 0) ? 8'h01 : seed[15:8];
      o = seed[23:16];
      c = (i == 0) ? 1'b0 : seed[24];
      sb = (i == 0) ? 1'b0 : seed[25];
      wr(`CRS_A_ACC, {24'h000000, a});
      ram_wr({1'b0, o}, m);
      wr(`CRS_A_STATUS, {31'h00000000, c});
      cmd(sb ? `CRS_OP_SUB_BORROW : `CRS_OP_ADD_CARRY, o, 8'h00, 2'h0);
      mm = sb ? ~m : m;
      r = a + mm + c;
      rchk(`CRS_A_ACC, "acc", {24'h000000, r[7:0]});
      rchk(`CRS_A_STATUS, "flags", {24'h000000, st_exp(a, mm, r)});
    end
    rchk(`CRS_A_PCNT, "pcnt count", 32'h00000010);
    wr(`CRS_A_ACC, 32'h00000058);
    ram_wr(9'h010, 8'h46);
    wr(`CRS_A_STATUS, 32'h00000008);
    cmd(`CRS_OP_ADD_CARRY, 8'h10, 8'h00, 2'h0);
    rchk(`CRS_A_ACC, "decimal sum", 32'h00000004);
    apb(1'b0, `CRS_A_STATUS, 32'h00000000);
    chk("decimal carry", 32'h00000001, q & 32'h00000001);
    wr(`CRS_A_IDX_X, 32'h00000030);
    ram_wr(9'h005, 8'hA5);
    cmd(`CRS_OP_LOAD, 8'hD5, 8'h00, 2'h1);
    rchk(`CRS_A_ACC, "indexed load", 32'h000000A5);
    wr(`CRS_A_ACC, 32'h00000055);
    wr(`CRS_A_IDX_X, 32'h00000040);
    ram_wr(9'h040, 8'h11);
    ram_wr(9'h041, 8'h22);
    wr(`CRS_A_STATUS, 32'h00000020);
    cmd(`CRS_OP_ADD_CARRY, 8'h41, 8'h00, 2'h0);
    ram_chk(9'h041, 8'hFF, 8'h33);
    rchk(`CRS_A_ACC, "acc kept", 32'h00000055);
    wr(`CRS_A_STATUS, 32'h00000000);
    ram_wr(9'h042, 8'h40);
    cmd(`CRS_OP_TEST_BITS, 8'h42, 8'h00, 2'h0);
    apb(1'b0, `CRS_A_STATUS, 32'h00000000);
    chk("bit test", 32'h00000040, q & 32'h000000C0);
    wr(`CRS_A_ACC, 32'h00000012);
    ram_wr(9'h043, 8'h34);
    cmd(`CRS_OP_PRODUCT, 8'h43, 8'h00, 2'h0);
    rchk(`CRS_A_ACC, "product low", 32'h000000A8);
    rchk(`CRS_A_IDX_Y, "product high", 32'h00000003);
    cmd(`CRS_OP_DIVIDE, 8'h43, 8'h00, 2'h0);
    rchk(`CRS_A_ACC, "quotient", 32'h00000012);
    rchk(`CRS_A_IDX_Y, "remainder", 32'h00000000);
    wr(`CRS_A_ACC, 32'h00000081);
    cmd(`CRS_OP_FLAGS, 8'h01, 8'h01, 2'h0);
    cmd(`CRS_OP_ROTATE_L, 8'h00, 8'h00, 2'h0);
    rchk(`CRS_A_ACC, "rotate", 32'h00000003);
    rchk(`CRS_A_STATUS, "rotate flags", 32'h00000041);
    cmd(`CRS_OP_SHIFT_L, 8'h00, 8'h00, 2'h0);
    cmd(`CRS_OP_STORE, 8'h44, 8'h00, 2'h0);
    ram_chk(9'h044, 8'hFF, 8'h06);
    cmd(`CRS_OP_BRANCH, 8'h10, 8'h00, 2'h0);
    cmd(`CRS_OP_BRANCH, 8'h10, 8'h09, 2'h0);
    rchk(`CRS_A_PCNT, "branch", 32'h0000002C);
    for (int k = 0; k < 2; k++) begin
      cmd(k ? `CRS_OP_UNSUP_SLOW_B : `CRS_OP_UNSUP_FAST_A, 8'h00, 8'h00, 2'h0);
      rchk(`CRS_A_STATE, "unsupported", 32'h00FF0004);
      wr(`CRS_A_STATE, 32'h00000004);
    end
    wr(`CRS_A_MODE, 32'h00000004);
    wr(`CRS_A_ACC, 32'h0000005A);
    cmd(`CRS_OP_PUSH_ACC, 8'h00, 8'h00, 2'h0);
    rchk(`CRS_A_SPTR, "push sp", 32'h000000FE);
    ram_chk(9'h1FF, 8'hFF, 8'h5A);
    rchk(`CRS_A_STATE, "stack addr", 32'h01FE0000);
    wr(`CRS_A_ACC, 32'h00000000);
    cmd(`CRS_OP_PULL_ACC, 8'h00, 8'h00, 2'h0);
    rchk(`CRS_A_ACC, "pull acc", 32'h0000005A);
    wr(`CRS_A_STATUS, 32'h00000001);
    cmd(`CRS_OP_PUSH_STATUS, 8'h00, 8'h00, 2'h0);
    wr(`CRS_A_STATUS, 32'h00000000);
    cmd(`CRS_OP_PULL_STATUS, 8'h00, 8'h00, 2'h0);
    rchk(`CRS_A_STATUS, "pull status", 32'h00000001);
    cmd(`CRS_OP_CALL, 8'h34, 8'h12, 2'h0);
    rchk(`CRS_A_PCNT, "call pcnt", 32'h00001234);
    rchk(`CRS_A_SPTR, "call sp", 32'h000000FD);
    wr(`CRS_A_STATUS, 32'h00000004);
    cmd(`CRS_OP_SW_BREAK, 8'h00, 8'h00, 2'h0);
    rchk(`CRS_A_PCNT, "break pcnt", 32'h0000FFDC);
    rchk(`CRS_A_SPTR, "break sp", 32'h000000FA);
    ram_chk(9'h1FB, 8'h10, 8'h10);
    rchk(`CRS_A_STATUS, "live break", 32'h00000004);
    irq_request <= 1'b1;
    n = 0;
    repeat (20) begin
      @(posedge clk);
      n += irq_ack;
    end
    chk("masked ack", 32'h00000000, n);
    wr(`CRS_A_STATUS, 32'h00000000);
    for (int k = 0; k < 40 && irq_ack !== 1'b1; k++) @(posedge clk);
    chk("ack", 32'h00000001, {31'h00000000, irq_ack});
    irq_request <= 1'b0;
    @(posedge clk);
    rchk(`CRS_A_PCNT, "irq pcnt", 32'h0000FFFC);
    rchk(`CRS_A_STATUS, "irq mask", 32'h00000004);
    for (int k = 0; k < 2; k++) begin
      cmd(k ? `CRS_OP_STOP : `CRS_OP_WAIT, 8'h00, 8'h00, 2'h0);
      chk("sleep", 32'h00000001, {31'h00000000, k ? core_stopped : core_waiting});
      irq_request <= 1'b1;
      for (int j = 0; j < 10 && (core_waiting | core_stopped) !== 1'b0; j++) @(posedge clk);
      irq_request <= 1'b0;
      chk("awake", 32'h00000000, {30'h00000000, core_waiting, core_stopped});
      @(posedge clk);
    end
    apb(1'b0, 8'h2C, 32'h00000000);
    chk("unmapped read", 32'h00000001, {31'h00000000, e});
    chk("unmapped data", 32'h00000000, q);
    wr(8'h02, 32'h00000000);
    chk("misaligned write", 32'h00000001, {31'h00000000, e});
    wrap_up();
  end
endmodule // cpu_register_set_tb
